//--- logic/pmbus_cfg_pkg.sv
// Command codes, field layouts, defaults and carriers of the PMBus configuration block.
`default_nettype none
package pmbus_cfg_pkg;

   // Command codes understood by the interpreter.
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
   localparam logic [7:0] CMD_STORE_ALL = 8'h11;
   localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
   localparam logic [7:0] CMD_VOUT_SET = 8'h21;
   localparam logic [7:0] CMD_VIN_ON = 8'h35;
   localparam logic [7:0] CMD_VIN_OFF = 8'h36;
   localparam logic [7:0] CMD_TON_DELAY = 8'h60;
   localparam logic [7:0] CMD_TON_RISE = 8'h61;
   localparam logic [7:0] CMD_READ_VIN = 8'h88;
   localparam logic [7:0] CMD_READ_VOUT = 8'h8B;
   localparam logic [7:0] CMD_VOUT_CAL = 8'hD0;
   localparam logic [7:0] CMD_VIN_CAL_OFF = 8'hD1;
   localparam logic [7:0] CMD_VIN_CAL_GAIN = 8'hD2;

   // Field positions in the operation and on/off configuration bytes.
   localparam int OP_ENABLE_BIT = 7;
   localparam int OP_MARGIN_LSB = 2;
   localparam int OOC_CMD_BIT = 3;
   localparam logic [7:0] OOC_FIXED_BITS = 8'h17;
   localparam logic [7:0] OPERATION_RESET = 8'h00;
   localparam logic OOC_CMD_RESET = 1'b1;

   // Linear format exponents and the output mode byte.
   localparam logic [4:0] EXP_VIN = 5'h1D;
   localparam logic [4:0] EXP_TON = 5'h1F;
   localparam logic [7:0] VOUT_MODE_BYTE = 8'h14;
   localparam int GAIN_SHIFT = 13;

   // Accepted mantissa ranges.
   localparam logic [10:0] VIN_MANT_MIN = 11'h100;
   localparam logic [10:0] VIN_MANT_MAX = 11'h170;
   localparam logic [10:0] TON_DELAY_MIN = 11'h014;
   localparam logic [10:0] TON_RISE_MIN = 11'h01E;
   localparam logic [10:0] TON_MANT_MAX = 11'h3E8;
   localparam logic [15:0] VOUT_SET_MIN = 16'h819A;
   localparam logic [15:0] VOUT_SET_MAX = 16'hD333;

   // Power-on defaults of the storable settings.
   localparam logic [15:0] VOUT_SET_RESET = 16'hC000;
   localparam logic [10:0] VIN_ON_RESET = 11'h110;
   localparam logic [10:0] VIN_OFF_RESET = 11'h100;
   localparam logic [10:0] TON_DELAY_RESET = 11'h014;
   localparam logic [10:0] TON_RISE_RESET = 11'h01E;

   // Factory calibration defaults.
   localparam logic [15:0] VOUT_CAL_DEFAULT = 16'h0000;
   localparam logic [10:0] VIN_CAL_OFF_DEFAULT = 11'h000;
   localparam logic [15:0] VIN_CAL_GAIN_DEFAULT = 16'h2000;

   // Bus frame states, Gray coded along idle, address, write, read.
   typedef enum logic [1:0] {
      FR_IDLE = 2'b00,
      FR_ADDR = 2'b01,
      FR_WRITE = 2'b11,
      FR_READ = 2'b10
   } frame_state_t;

   // Margin selection decoded from the operation byte.
   typedef enum logic [1:0] {
      MARGIN_OFF = 2'b00,
      MARGIN_LOW = 2'b01,
      MARGIN_HIGH = 2'b10
   } margin_t;

   // Storable settings, mantissas only.
   typedef struct packed {
      logic [15:0] vout_set;
      logic [10:0] vin_on;
      logic [10:0] vin_off;
      logic [10:0] ton_delay;
      logic [10:0] ton_rise;
   } settings_t;

   // Raw converter readings.
   typedef struct packed {
      logic [15:0] vout_raw;
      logic [10:0] vin_raw;
   } telemetry_t;

endpackage
`default_nettype wire

//--- logic/pmbus_config_and_telemetry.sv
// PMBus target command interpreter with on/off control, limits, store command and calibrated telemetry.
//
// Operation
// - Bus address is two octal digits, high digit pin then low digit pin.
// - Output-voltage words are 16-bit unsigned mantissas at exponent -12.
// - Other quantities use 5-bit exponent and 11-bit signed mantissa; the input gain is a plain 16-bit word over 8192.
// - Operation bit 7 is the output enable, one enables.
// - Margin codes 00XX off, 0110 low, 1010 high.
// - Only low five on/off config bits exist, default ones, bit 3 writable.
// - Start needs both the on/off pin and the operation command as configured.
// - Command-response bit zero ignores the enable bit, one obeys it.
// - The on/off pin must be asserted before the output starts.
// - Settings reach storage only through the store-all command.
// - Input turn-on and turn-off thresholds form lockout with hysteresis.
// - Threshold writes accepted only between 32 and 46 volts, 0.125 V steps.
// - Threshold words carry exponent -3 and a positive 11-bit mantissa.
// - Store-all saves thresholds, soft-start times and output setpoint.
// - Delay 10 to 500 ms, rise 15 to 500 ms, 0.5 ms steps.
// - Soft-start words carry exponent -1 and a positive 11-bit mantissa.
// - Output setpoint limited 8.10 to 13.20 V, exponent reported by mode.
// - Output reading is a 16-bit unsigned mantissa at exponent -12.
// - Output offset is signed 16-bit, added to the raw reading.
// - Input reading uses exponent -3 and a positive 11-bit mantissa.
// - Input offset reported with exponent -3, 125 mV resolution.
// - Input reading equals raw times gain over 8192 plus offset.
`timescale 1ns/1ns
`default_nettype none
module pmbus_config_and_telemetry
   import pmbus_cfg_pkg::*;
#(
   parameter logic [15:0] VOUT_CAL = VOUT_CAL_DEFAULT,
   parameter logic [10:0] VIN_CAL_OFF = VIN_CAL_OFF_DEFAULT,
   parameter logic [15:0] VIN_CAL_GAIN = VIN_CAL_GAIN_DEFAULT
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic link_clock,
   input wire logic link_data_in,
   output logic link_data_out,
   output logic link_data_oe,
   input wire logic [2:0] addr_digit_low_pin,
   input wire logic [2:0] addr_digit_high_pin,
   input wire logic on_off_pin,
   input wire telemetry_t telemetry_in,
   output settings_t settings_out,
   output logic nvm_store,
   output logic output_run,
   output margin_t margin_select,
   output logic input_ok,
   output logic [6:0] bus_address
);

   // Range check for a linear word with a fixed exponent.
   function automatic logic lin_ok(input logic [15:0] word, input logic [4:0] expo,
                                   input logic [10:0] lo, input logic [10:0] hi);
      lin_ok = (word[15:11] == expo) && (word[10:0] >= lo) && (word[10:0] <= hi);
   endfunction

   // Main-domain state.
   logic [1:0] scl_sync_reg, sda_sync_reg, onoff_sync_reg, tgl_sync_reg;
   logic [5:0] addr_sync1_reg, addr_sync2_reg;
   logic scl_prev_reg, sda_prev_reg, tgl_prev_reg;
   logic frame_clear_reg;
   frame_state_t state_reg, state_next;
   logic [2:0] byte_cnt_reg;
   logic [7:0] cmd_reg, data_lo_reg, data_hi_reg, tx_byte_reg;
   logic [7:0] operation_reg;
   logic ooc_cmd_reg;
   settings_t settings_reg;
   logic nvm_store_reg, run_reg, input_ok_reg;
   margin_t margin_reg;
   logic [6:0] address_reg;
   logic [10:0] vin_read_reg;
   logic [15:0] vout_read_reg;

   // Link-domain state.
   logic [5:0] laddr1_reg, laddr2_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg, rx_byte_reg;
   logic byte_tgl_reg, first_reg, addressed_reg, reading_reg, nack_reg;
   logic oe_reg, out_reg;

   // Start and stop are seen on the synchronised pins while the clock line is high.
   wire scl_now = scl_sync_reg[1];
   wire sda_now = sda_sync_reg[1];
   wire start_seen = scl_now && scl_prev_reg && sda_prev_reg && !sda_now;
   wire stop_seen = scl_now && scl_prev_reg && !sda_prev_reg && sda_now;
   wire byte_ev = tgl_sync_reg[1] ^ tgl_prev_reg;

   // Pins from outside pass two flip-flops; the byte toggle is cleared with each start.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         scl_sync_reg <= 2'b11;
         sda_sync_reg <= 2'b11;
         onoff_sync_reg <= 2'b00;
         addr_sync1_reg <= 6'h00;
         addr_sync2_reg <= 6'h00;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[0], link_clock};
         sda_sync_reg <= {sda_sync_reg[0], link_data_in};
         onoff_sync_reg <= {onoff_sync_reg[0], on_off_pin};
         addr_sync1_reg <= {addr_digit_high_pin, addr_digit_low_pin};
         addr_sync2_reg <= addr_sync1_reg;
         scl_prev_reg <= scl_now;
         sda_prev_reg <= sda_now;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n || start_seen)
      begin
         tgl_sync_reg <= 2'b00;
         tgl_prev_reg <= 1'b0;
      end
      else
      begin
         tgl_sync_reg <= {tgl_sync_reg[0], byte_tgl_reg};
         tgl_prev_reg <= tgl_sync_reg[1];
      end
   end

   // Address digits: high digit times eight plus low digit.
   wire [6:0] address_next = {1'b0, addr_sync2_reg[5:3], addr_sync2_reg[2:0]};

   // Frame sequencing: first byte is the address, then command and data or read answers.
   always_comb
   begin
      state_next = state_reg;
      if (start_seen)
         state_next = FR_ADDR;
      else if (stop_seen)
         state_next = FR_IDLE;
      else if (byte_ev && state_reg == FR_ADDR)
         state_next = rx_byte_reg[0] ? FR_READ : FR_WRITE;
   end

   // Read answers, low byte first.
   wire [7:0] ooc_value = OOC_FIXED_BITS | {4'h0, ooc_cmd_reg, 3'b000};
   wire [15:0] rsp_word =
      (cmd_reg == CMD_OPERATION) ? {8'h00, operation_reg} :
      (cmd_reg == CMD_ON_OFF_CONFIG) ? {8'h00, ooc_value} :
      (cmd_reg == CMD_VOUT_MODE) ? {8'h00, VOUT_MODE_BYTE} :
      (cmd_reg == CMD_VOUT_SET) ? settings_reg.vout_set :
      (cmd_reg == CMD_VIN_ON) ? {EXP_VIN, settings_reg.vin_on} :
      (cmd_reg == CMD_VIN_OFF) ? {EXP_VIN, settings_reg.vin_off} :
      (cmd_reg == CMD_TON_DELAY) ? {EXP_TON, settings_reg.ton_delay} :
      (cmd_reg == CMD_TON_RISE) ? {EXP_TON, settings_reg.ton_rise} :
      (cmd_reg == CMD_READ_VOUT) ? vout_read_reg :
      (cmd_reg == CMD_READ_VIN) ? {EXP_VIN, vin_read_reg} :
      (cmd_reg == CMD_VOUT_CAL) ? VOUT_CAL :
      (cmd_reg == CMD_VIN_CAL_OFF) ? {EXP_VIN, VIN_CAL_OFF} :
      (cmd_reg == CMD_VIN_CAL_GAIN) ? VIN_CAL_GAIN : 16'hFFFF;

   // Frame state, byte capture and the next byte to send.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_reg <= FR_IDLE;
         frame_clear_reg <= 1'b1;
         byte_cnt_reg <= 3'h0;
         cmd_reg <= 8'h00;
         data_lo_reg <= 8'h00;
         data_hi_reg <= 8'h00;
         tx_byte_reg <= 8'hFF;
      end
      else
      begin
         state_reg <= state_next;
         frame_clear_reg <= start_seen || (state_next == FR_IDLE);
         if (start_seen)
            byte_cnt_reg <= 3'h0;
         if (byte_ev && state_reg == FR_ADDR && rx_byte_reg[0])
         begin
            tx_byte_reg <= rsp_word[7:0];
            byte_cnt_reg <= 3'h0;
         end
         else if (byte_ev && state_reg == FR_READ)
         begin
            tx_byte_reg <= (byte_cnt_reg == 3'h0) ? rsp_word[15:8] : 8'hFF;
            byte_cnt_reg <= (byte_cnt_reg == 3'h7) ? byte_cnt_reg : byte_cnt_reg + 3'h1;
         end
         else if (byte_ev && state_reg == FR_WRITE)
         begin
            if (byte_cnt_reg == 3'h0)
               cmd_reg <= rx_byte_reg;
            if (byte_cnt_reg == 3'h1)
               data_lo_reg <= rx_byte_reg;
            if (byte_cnt_reg == 3'h2)
               data_hi_reg <= rx_byte_reg;
            byte_cnt_reg <= (byte_cnt_reg == 3'h7) ? byte_cnt_reg : byte_cnt_reg + 3'h1;
         end
      end
   end

   // Writes take effect at stop, only with the exact byte count and in-range data.
   wire commit = stop_seen && (state_reg == FR_WRITE);
   wire commit_send = commit && (byte_cnt_reg == 3'h1);
   wire commit_byte = commit && (byte_cnt_reg == 3'h2);
   wire commit_word = commit && (byte_cnt_reg == 3'h3);
   wire [15:0] data_word = {data_hi_reg, data_lo_reg};
   wire vin_word_ok = lin_ok(data_word, EXP_VIN, VIN_MANT_MIN, VIN_MANT_MAX);
   wire delay_ok = lin_ok(data_word, EXP_TON, TON_DELAY_MIN, TON_MANT_MAX);
   wire rise_ok = lin_ok(data_word, EXP_TON, TON_RISE_MIN, TON_MANT_MAX);
   wire vout_ok = (data_word >= VOUT_SET_MIN) && (data_word <= VOUT_SET_MAX);

   // Control registers and the storable settings.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         operation_reg <= OPERATION_RESET;
         ooc_cmd_reg <= OOC_CMD_RESET;
         settings_reg <= '{VOUT_SET_RESET, VIN_ON_RESET, VIN_OFF_RESET, TON_DELAY_RESET, TON_RISE_RESET};
         nvm_store_reg <= 1'b0;
      end
      else
      begin
         if (commit_byte && cmd_reg == CMD_OPERATION)
            operation_reg <= data_lo_reg;
         if (commit_byte && cmd_reg == CMD_ON_OFF_CONFIG)
            ooc_cmd_reg <= data_lo_reg[OOC_CMD_BIT];
         if (commit_word && cmd_reg == CMD_VIN_ON && vin_word_ok)
            settings_reg.vin_on <= data_word[10:0];
         if (commit_word && cmd_reg == CMD_VIN_OFF && vin_word_ok)
            settings_reg.vin_off <= data_word[10:0];
         if (commit_word && cmd_reg == CMD_TON_DELAY && delay_ok)
            settings_reg.ton_delay <= data_word[10:0];
         if (commit_word && cmd_reg == CMD_TON_RISE && rise_ok)
            settings_reg.ton_rise <= data_word[10:0];
         if (commit_word && cmd_reg == CMD_VOUT_SET && vout_ok)
            settings_reg.vout_set <= data_word;
         nvm_store_reg <= commit_send && (cmd_reg == CMD_STORE_ALL);
      end
   end

   // Calibrated input reading: raw times gain over 8192, plus signed offset, clamped.
   wire [26:0] vin_product = telemetry_in.vin_raw * VIN_CAL_GAIN;
   wire [13:0] vin_scaled = vin_product[26:GAIN_SHIFT];
   wire [14:0] vin_sum = {1'b0, vin_scaled} + {{4{VIN_CAL_OFF[10]}}, VIN_CAL_OFF};
   wire [10:0] vin_read_next = vin_sum[14] ? 11'h000 :
                               (vin_sum[13:10] != 4'h0) ? 11'h3FF : vin_sum[10:0];

   // Calibrated output reading: raw plus signed offset, clamped to 16 unsigned bits.
   wire [17:0] vout_sum = {2'b00, telemetry_in.vout_raw} + {{2{VOUT_CAL[15]}}, VOUT_CAL};
   wire [15:0] vout_read_next = vout_sum[17] ? 16'h0000 :
                                vout_sum[16] ? 16'hFFFF : vout_sum[15:0];

   // Lockout with hysteresis: rise at or above turn-on, fall below turn-off.
   wire input_ok_next = input_ok_reg ? (vin_read_reg >= settings_reg.vin_off)
                                     : (vin_read_reg >= settings_reg.vin_on);

   // Start permission: pin always required, enable bit only when command response is on.
   wire pin_active = onoff_sync_reg[1];
   wire op_permit = ooc_cmd_reg ? operation_reg[OP_ENABLE_BIT] : 1'b1;
   wire run_next = pin_active && op_permit && input_ok_reg;

   // Margin decode of operation bits 5 to 2.
   wire [3:0] margin_code = operation_reg[OP_MARGIN_LSB +: 4];
   wire margin_t margin_next = (margin_code == 4'h6) ? MARGIN_LOW :
                               (margin_code == 4'hA) ? MARGIN_HIGH : MARGIN_OFF;

   // Telemetry, lockout, run and address registers.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         vin_read_reg <= 11'h000;
         vout_read_reg <= 16'h0000;
         input_ok_reg <= 1'b0;
         run_reg <= 1'b0;
         margin_reg <= MARGIN_OFF;
         address_reg <= 7'h00;
      end
      else
      begin
         vin_read_reg <= vin_read_next;
         vout_read_reg <= vout_read_next;
         input_ok_reg <= input_ok_next;
         run_reg <= run_next;
         margin_reg <= margin_next;
         address_reg <= address_next;
      end
   end

   // Link domain: the address crosses through two flip-flops on the link clock.
   always_ff @(posedge link_clock)
   begin
      laddr1_reg <= address_reg[5:0];
      laddr2_reg <= laddr1_reg;
   end

   // Byte shifter on the rising link clock; a start or idle bus clears it at once.
   wire [7:0] byte_now = {shift_reg[6:0], link_data_in};
   wire addr_match = (byte_now[7:1] == {1'b0, laddr2_reg});
   always_ff @(posedge link_clock or posedge frame_clear_reg)
   begin
      if (frame_clear_reg)
      begin
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         rx_byte_reg <= 8'h00;
         byte_tgl_reg <= 1'b0;
         first_reg <= 1'b1;
         addressed_reg <= 1'b0;
         reading_reg <= 1'b0;
         nack_reg <= 1'b0;
      end
      else if (bit_cnt_reg != 4'h8)
      begin
         shift_reg <= byte_now;
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         if (bit_cnt_reg == 4'h7)
         begin
            rx_byte_reg <= byte_now;
            if (first_reg)
            begin
               addressed_reg <= addr_match;
               reading_reg <= byte_now[0];
            end
            if (first_reg ? addr_match : addressed_reg)
               byte_tgl_reg <= ~byte_tgl_reg;
         end
      end
      else
      begin
         bit_cnt_reg <= 4'h0;
         first_reg <= 1'b0;
         if (reading_reg && !first_reg)
            nack_reg <= link_data_in;
      end
   end

   // Open-drain drive on the falling link clock: acknowledge and read data.
   wire ack_now = (bit_cnt_reg == 4'h8) && addressed_reg && (first_reg || !reading_reg);
   wire send_now = (bit_cnt_reg != 4'h8) && !first_reg && addressed_reg && reading_reg && !nack_reg;
   wire [2:0] tx_index = 3'h7 - bit_cnt_reg[2:0];
   always_ff @(negedge link_clock or posedge frame_clear_reg)
   begin
      if (frame_clear_reg)
      begin
         oe_reg <= 1'b0;
         out_reg <= 1'b0;
      end
      else
      begin
         oe_reg <= ack_now || (send_now && !tx_byte_reg[tx_index]);
         out_reg <= 1'b0;
      end
   end

   // Outputs straight from flip-flops.
   assign link_data_out = out_reg;
   assign link_data_oe = oe_reg;
   assign settings_out = settings_reg;
   assign nvm_store = nvm_store_reg;
   assign output_run = run_reg;
   assign margin_select = margin_reg;
   assign input_ok = input_ok_reg;
   assign bus_address = address_reg;

endmodule // pmbus_config_and_telemetry
`default_nettype wire

//--- verification/pmbus_config_and_telemetry_assertions.sv
// Port checks of the PMBus configuration block.
`timescale 1ns/1ns
`default_nettype none
module pmbus_config_and_telemetry_checker
   import pmbus_cfg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic link_clock,
   input wire logic link_data_in,
   input wire logic [2:0] addr_digit_low_pin,
   input wire logic [2:0] addr_digit_high_pin,
   input wire logic on_off_pin,
   input wire settings_t settings_out,
   input wire logic nvm_store,
   input wire logic output_run,
   input wire margin_t margin_select,
   input wire logic input_ok,
   input wire logic [6:0] bus_address
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // The address follows settled digit pins.
   AST_ADDR_DIGITS: assert property (($stable(addr_digit_high_pin) && $stable(addr_digit_low_pin)) [*5]
      |-> bus_address == {1'b0, addr_digit_high_pin, addr_digit_low_pin}) else $error("address mismatch");
   // Running needs the pin and the input.
   AST_RUN_NEEDS_PIN: assert property (!on_off_pin [*5] |-> !output_run) else $error("run without pin");
   AST_RUN_NEEDS_INPUT: assert property ($rose(output_run) |-> $past(input_ok)) else $error("run without input");
   // Only three margin selections exist.
   AST_MARGIN_CODE: assert property (margin_select != 2'b11) else $error("bad margin code");
   // The store pulse is one cycle long, after a frame.
   AST_STORE_ONE_CYCLE: assert property (nvm_store |=> !nvm_store) else $error("store too long");
   AST_STORE_AFTER_STOP: assert property (nvm_store |-> link_clock && link_data_in) else $error("store in frame");
   // Input thresholds and output setpoint stay inside their accepted ranges.
   AST_VIN_LIMITS: assert property (settings_out.vin_on >= VIN_MANT_MIN && settings_out.vin_on <= VIN_MANT_MAX
      && settings_out.vin_off >= VIN_MANT_MIN && settings_out.vin_off <= VIN_MANT_MAX) else $error("vin range");
   AST_VOUT_LIMITS: assert property (settings_out.vout_set >= VOUT_SET_MIN
      && settings_out.vout_set <= VOUT_SET_MAX) else $error("vout range");
   // Main scenarios reached.
   COV_STORE: cover property (nvm_store);
   COV_RUN: cover property ($rose(output_run));
   COV_MARGIN_HIGH: cover property (margin_select == MARGIN_HIGH);
endmodule // pmbus_config_and_telemetry_checker

bind pmbus_config_and_telemetry pmbus_config_and_telemetry_checker checker_u (
   .clock, .rst_n, .link_clock, .link_data_in, .addr_digit_low_pin, .addr_digit_high_pin,
   .on_off_pin, .settings_out, .nvm_store, .output_run, .margin_select, .input_ok, .bus_address);
`default_nettype wire

//--- verification/pmbus_master_model.sv
// Behavioural bus master driving the serial clock and data pull-down.
`timescale 1ns/1ns
`default_nettype none
module pmbus_master_model (
   input wire logic sda_in,
   output logic scl,
   output logic sda_pull,
   output logic [7:0] rd_byte,
   output logic rd_strobe
);
   int nack_total = 0;
   int stretch = 0;

   // Between frames the clock stands high and data is released.
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
      rd_byte = 8'h00;
      rd_strobe = 1'b0;
   end

   // One clock pulse: data set while low, sampled mid-high.
   task automatic pulse(input logic drv, output logic seen);
      sda_pull = !drv;
      #(8 + stretch);
      scl = 1'b1;
      #8;
      seen = sda_in;
      #8;
      scl = 1'b0;
      #8;
   endtask

   // Start or repeated start, then the gap before the first clock.
   task automatic bus_start();
      sda_pull = 1'b0;
      #8;
      scl = 1'b1;
      #8;
      sda_pull = 1'b1;
      #1000;
      scl = 1'b0;
      #8;
   endtask

   // Stop, then an idle gap.
   task automatic bus_stop();
      sda_pull = 1'b1;
      #8;
      scl = 1'b1;
      #8;
      sda_pull = 1'b0;
      #1000;
   endtask

   task automatic put_byte(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(b[i], s);
      pulse(1'b1, s);
      if (s) nack_total++;
   endtask

   // The last read byte is answered with a not-acknowledge.
   task automatic get_byte(input logic last);
      logic s;
      logic [7:0] b;
      for (int i = 7; i >= 0; i--)
      begin
         pulse(1'b1, s);
         b[i] = s;
      end
      pulse(last, s);
      rd_byte = b;
      rd_strobe = 1'b1;
      #4;
      rd_strobe = 1'b0;
   endtask

   task automatic write(input logic [6:0] adr, input logic [7:0] cmd, input int n, input logic [15:0] d);
      bus_start();
      put_byte({adr, 1'b0});
      put_byte(cmd);
      for (int i = 0; i < n; i++) put_byte(d[8*i +: 8]);
      bus_stop();
   endtask

   task automatic read(input logic [6:0] adr, input logic [7:0] cmd, input int n);
      bus_start();
      put_byte({adr, 1'b0});
      put_byte(cmd);
      bus_start();
      put_byte({adr, 1'b1});
      for (int i = 0; i < n; i++) get_byte(i == n - 1);
      bus_stop();
   endtask
endmodule // pmbus_master_model
`default_nettype wire

//--- verification/test_pmbus_config_and_telemetry.sv
// Self-checking bench for the PMBus configuration block.
`timescale 1ns/1ns
`default_nettype none
module test_pmbus_config_and_telemetry
   import pmbus_cfg_pkg::*;
;
   localparam logic [6:0] ADR = 7'h1A;
   logic clock = 1'b0, rst_n = 1'b0, on_off_pin = 1'b0;
   logic [2:0] lo_pin = 3'h0, hi_pin = 3'h0;
   telemetry_t tel = '0;
   settings_t set_o, exp_set;
   margin_t margin;
   wire logic scl, pull, oe, dout, strobe, run, in_ok, store;
   wire logic [7:0] rbyte;
   wire logic [6:0] baddr;
   wire logic sda = !(oe || pull);
   logic [31:0] rnd = 32'h0000003E;
   int err_total = 0, n_checks = 0;
   logic [63:0] rq[$], sq[$];
   logic [7:0] op_tab[6] = '{8'h98, 8'hA8, 8'h84, 8'h8C, 8'hB8, 8'h80};
   margin_t mg_tab[6] = '{MARGIN_LOW, MARGIN_HIGH, MARGIN_OFF, MARGIN_OFF, MARGIN_OFF, MARGIN_OFF};
   logic [10:0] vr_tab[5] = '{11'h090, 11'h085, 11'h080, 11'h085, 11'h090};
   logic ok_tab[5] = '{1, 1, 0, 0, 1};
   logic [7:0] wc[12] = '{CMD_VIN_ON, CMD_VIN_ON, CMD_VIN_ON, CMD_VIN_OFF, CMD_VIN_OFF, CMD_TON_DELAY,
      CMD_TON_DELAY, CMD_TON_RISE, CMD_VOUT_SET, CMD_VOUT_SET, CMD_VOUT_SET, CMD_VOUT_SET};
   logic [15:0] wd[12] = '{16'hE930, 16'hE971, 16'hF130, 16'hE910, 16'hE910, 16'hF813,
      16'hFBE8, 16'hF832, 16'h8199, 16'h819A, 16'hD334, 16'hD333};
   logic wa[12] = '{1, 0, 0, 0, 1, 0, 1, 1, 0, 1, 0, 1};

   pmbus_config_and_telemetry #(.VOUT_CAL(16'hFFF0), .VIN_CAL_OFF(11'h7FE), .VIN_CAL_GAIN(16'h4000)) dut_u (
      .clock, .rst_n, .link_clock(scl), .link_data_in(sda), .link_data_out(dout),
      .link_data_oe(oe), .addr_digit_low_pin(lo_pin), .addr_digit_high_pin(hi_pin), .on_off_pin,
      .telemetry_in(tel), .settings_out(set_o), .nvm_store(store), .output_run(run),
      .margin_select(margin), .input_ok(in_ok), .bus_address(baddr));
   pmbus_master_model m_u (.sda_in(sda), .scl, .sda_pull(pull), .rd_byte(rbyte), .rd_strobe(strobe));

   // Main clock of 4 ns.
   initial
   begin
      forever #2 clock = !clock;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   // Notes a read's expected bytes, low first, then runs it.
   task automatic rd(input logic [7:0] cmd, input int n, input logic [15:0] w);
      for (int i = 0; i < n; i++) rq.push_back(64'(w[8*i +: 8]));
      m_u.read(ADR, cmd, n);
   endtask

   // Each byte read is compared with the oldest note.
   always @(posedge strobe)
   begin
      chk(64'(rbyte), rq.size() > 0 ? rq.pop_front() : 64'h1FF);
   end

   // Each store pulse must match the oldest noted snapshot.
   always @(negedge clock)
   begin
      if (rst_n && store === 1'b1)
         chk(64'(set_o), sq.size() > 0 ? sq.pop_front() : 64'h0);
   end

   // Cuts a hang short.
   initial
   begin
      #300000;
      err_total++;
      test_done();
   end

   initial
   begin
      exp_set = '{VOUT_SET_RESET, VIN_ON_RESET, VIN_OFF_RESET, TON_DELAY_RESET, TON_RISE_RESET};
      cyc(12);
      rst_n = 1'b1;
      chk(64'(set_o), 64'(exp_set));
      for (int i = 0; i < 4; i++)
      begin
         rnd = xs(rnd);
         {hi_pin, lo_pin} = rnd[5:0];
         cyc(8);
         chk(64'(baddr), {58'h0, rnd[5:0]});
      end
      {hi_pin, lo_pin} = 6'h1A;
      on_off_pin = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         tel.vin_raw = vr_tab[i];
         cyc(8);
         chk(64'(in_ok), 64'(ok_tab[i]));
         chk(64'(run), 64'h0);
      end
      for (int i = 0; i < 6; i++)
      begin
         m_u.write(ADR, CMD_OPERATION, 1, {8'h00, op_tab[i]});
         chk(64'(margin), 64'(mg_tab[i]));
         chk(64'(run), 64'h1);
      end
      m_u.write(7'h1B, CMD_OPERATION, 1, 16'h0000);
      chk(64'(run), 64'h1);
      chk(64'(m_u.nack_total), 64'h3);
      m_u.write(ADR, CMD_OPERATION, 1, 16'h0000);
      chk(64'(run), 64'h0);
      m_u.write(ADR, CMD_ON_OFF_CONFIG, 1, 16'h0000);
      chk(64'(run), 64'h1);
      rd(CMD_ON_OFF_CONFIG, 1, 16'h0017);
      cyc(1);
      on_off_pin = 1'b0;
      cyc(8);
      chk(64'(run), 64'h0);
      on_off_pin = 1'b1;
      m_u.write(ADR, CMD_ON_OFF_CONFIG, 1, 16'h00FF);
      rd(CMD_ON_OFF_CONFIG, 1, 16'h001F);
      chk(64'(run), 64'h0);
      m_u.stretch = 40;
      for (int i = 0; i < 12; i++)
      begin
         m_u.write(ADR, wc[i], (i == 3) ? 1 : 2, wd[i]);
         if (wa[i])
            case (wc[i])
               CMD_VIN_ON: exp_set.vin_on = wd[i][10:0];
               CMD_VIN_OFF: exp_set.vin_off = wd[i][10:0];
               CMD_TON_DELAY: exp_set.ton_delay = wd[i][10:0];
               CMD_TON_RISE: exp_set.ton_rise = wd[i][10:0];
               default: exp_set.vout_set = wd[i];
            endcase
         chk(64'(set_o), 64'(exp_set));
      end
      m_u.stretch = 0;
      cyc(1);
      rnd = xs(rnd);
      tel.vout_raw = rnd[15:0] | 16'h0100;
      tel.vin_raw = 11'h090;
      cyc(4);
      rd(CMD_READ_VOUT, 2, tel.vout_raw - 16'h0010);
      rd(CMD_READ_VIN, 2, {EXP_VIN, 11'h11E});
      rd(CMD_VOUT_CAL, 2, 16'hFFF0);
      rd(CMD_VIN_CAL_OFF, 2, {EXP_VIN, 11'h7FE});
      rd(CMD_VIN_CAL_GAIN, 2, 16'h4000);
      rd(CMD_VOUT_MODE, 1, {8'h00, VOUT_MODE_BYTE});
      rd(CMD_VOUT_SET, 2, 16'hD333);
      rd(8'h99, 2, 16'hFFFF);
      sq.push_back(64'(exp_set));
      m_u.write(ADR, CMD_STORE_ALL, 0, 16'h0000);
      for (int i = 0; i < 50 && sq.size() > 0; i++) cyc(1);
      chk(64'(sq.size()), 64'h0);
      chk(64'(rq.size()), 64'h0);
      chk(64'(dout), 64'h0);
      test_done();
   end
endmodule // test_pmbus_config_and_telemetry
`default_nettype wire
